// ---- core/slc_regs.v ----
`timescale 1ns/1ps
`include "slc_map.vh"
// ----------------------------------------
// Functional notes
// - trigger write with low byte zero toggles sweep run
// - hold 40-bit sweep start frequency
// - direction bit picks starting end
// - hold each step value times 500 us
// - zero count repeats; else stop after count
// - point count register sets list length
// - point write stores at pointer
// - zero point write rewinds pointer, enables
// - nonzero writes advance to 2047, then ignored
// - all-ones ends writes, freezes count
// - direction zero copies list to nonvolatile
// - direction one copies nonvolatile to list
// - save settings; reload them at reset
// - standby bit one powers down, zero wakes
// ----------------------------------------
module slc_regs #(
  parameter DEPTH = 2048,
  parameter AW = 11,
  parameter HOLD_UNIT_CYC = `SLC_HOLD_UNIT_CYC
) (
  input wire ref_clk_in,
  input wire nrst_in,
  input wire wr_in,
  input wire [7:0] addr_in,
  input wire [39:0] wdata_in,
  input wire [7:0] list_cfg_in,
  input wire [39:0] rf_freq_in,
  input wire rf_mode_in,
  output wire [39:0] freq_out,
  output wire sweep_running_out,
  output reg standby_out,
  output reg [31:0] points_out,
  output reg [AW-1:0] wr_ptr_out,
  output reg store_enable_out,
  output reg nv_busy_out,
  output reg [7:0] saved_list_cfg_out,
  output reg [39:0] saved_rf_freq_out,
  output reg saved_rf_mode_out
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [39:0] start_ff;
  reg [39:0] stop_ff;
  reg [39:0] step_ff;
  reg [31:0] hold_ff;
  reg [31:0] repeat_ff;
  reg trig_ff;
  reg [39:0] list_ram [0:DEPTH-1];
  reg [39:0] nv_ram [0:DEPTH-1];
  reg [39:0] sv_start_ff;
  reg [39:0] sv_stop_ff;
  reg [39:0] sv_step_ff;
  reg [31:0] sv_hold_ff;
  reg [31:0] sv_repeat_ff;
  reg sv_valid_ff;
  reg load_ff;
  reg nv_dir_ff;
  reg [AW-1:0] nv_idx_ff;
  reg [AW:0] nv_len_ff;
  function is_wr;
    input [7:0] a;
    input [7:0] off;
    begin
      is_wr = wr_in && (a == off);
    end
  endfunction
  // the host presents a whole field with one strobe, never partial bytes
  wire w_trig = is_wr(addr_in, `SLC_OFF_TRIG);
  wire w_store = is_wr(addr_in, `SLC_OFF_STORE);
  wire w_save = is_wr(addr_in, `SLC_OFF_SAVE);
  wire w_nv = is_wr(addr_in, `SLC_OFF_NVCOPY) && !nv_busy_out;
  // ----------------------------------------
  // settings
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_ff <= `SLC_RST_ZERO40;
      stop_ff <= `SLC_RST_ZERO40;
      step_ff <= `SLC_RST_ZERO40;
      hold_ff <= `SLC_RST_ZERO32;
      repeat_ff <= `SLC_RST_ZERO32;
      trig_ff <= 1'b0;
      standby_out <= 1'b0;
      load_ff <= 1'b1;
    end else begin
      // saved copy survives reset, so defaults reload the clock after release
      load_ff <= 1'b0;
      trig_ff <= w_trig && (wdata_in[7:0] == 8'h00);
      if (load_ff && sv_valid_ff) begin
        start_ff <= sv_start_ff;
        stop_ff <= sv_stop_ff;
        step_ff <= sv_step_ff;
        hold_ff <= sv_hold_ff;
        repeat_ff <= sv_repeat_ff;
      end else if (wr_in) begin
        case (addr_in)
          `SLC_OFF_START: start_ff <= wdata_in;
          `SLC_OFF_STOP: stop_ff <= wdata_in;
          `SLC_OFF_STEP: step_ff <= wdata_in;
          `SLC_OFF_HOLD: hold_ff <= wdata_in[31:0];
          `SLC_OFF_REPEAT: repeat_ff <= wdata_in[31:0];
          `SLC_OFF_LOWPWR: standby_out <= wdata_in[`SLC_LOWPWR_BIT];
          default: ;
        endcase
      end
    end
  end
  // ----------------------------------------
  // saved defaults, not reset (models memory)
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    if (w_save) begin
      sv_start_ff <= start_ff;
      sv_stop_ff <= stop_ff;
      sv_step_ff <= step_ff;
      sv_hold_ff <= hold_ff;
      sv_repeat_ff <= repeat_ff;
      saved_list_cfg_out <= list_cfg_in;
      saved_rf_freq_out <= rf_freq_in;
      saved_rf_mode_out <= rf_mode_in;
      // valid mark lives with the saved copy, else reset would forget it
      sv_valid_ff <= 1'b1;
    end
  end
  // ----------------------------------------
  // list pointer and point count
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_out <= {AW{1'b0}};
      store_enable_out <= 1'b0;
      points_out <= `SLC_RST_ZERO32;
    end else if (is_wr(addr_in, `SLC_OFF_POINTS)) begin
      points_out <= wdata_in[31:0];
    end else if (w_store) begin
      if (wdata_in == `SLC_RST_ZERO40) begin
        wr_ptr_out <= {AW{1'b0}};
        store_enable_out <= 1'b1;
      end else if (wdata_in == `SLC_STORE_END) begin
        store_enable_out <= 1'b0;
        points_out <= {{(32-AW){1'b0}}, wr_ptr_out};
      end else if (store_enable_out && wr_ptr_out != `SLC_PTR_LIMIT) begin
        wr_ptr_out <= wr_ptr_out + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end
  // ----------------------------------------
  // list memory and nonvolatile copy
  // ----------------------------------------
  wire store_now = w_store && store_enable_out && wdata_in != `SLC_RST_ZERO40 &&
                   wdata_in != `SLC_STORE_END && wr_ptr_out != `SLC_PTR_LIMIT;
  always @(posedge ref_clk_in) begin
    if (store_now) begin
      list_ram[wr_ptr_out] <= wdata_in;
    end
    // one word per clock; new copy commands are ignored while busy
    if (nv_busy_out && !nv_dir_ff) begin
      nv_ram[nv_idx_ff] <= list_ram[nv_idx_ff];
    end
    if (nv_busy_out && nv_dir_ff) begin
      list_ram[nv_idx_ff] <= nv_ram[nv_idx_ff];
    end
  end
  wire [AW:0] nv_next = {1'b0, nv_idx_ff} + {{AW{1'b0}}, 1'b1};
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nv_busy_out <= 1'b0;
      nv_dir_ff <= 1'b0;
      nv_idx_ff <= {AW{1'b0}};
      nv_len_ff <= {(AW+1){1'b0}};
    end else if (w_nv) begin
      nv_dir_ff <= wdata_in[`SLC_NVCOPY_DIR_BIT];
      nv_idx_ff <= {AW{1'b0}};
      // store length follows point count; restore copies the whole list
      nv_len_ff <= wdata_in[`SLC_NVCOPY_DIR_BIT] ? DEPTH[AW:0] :
                   (points_out > DEPTH ? DEPTH[AW:0] : points_out[AW:0]);
      nv_busy_out <= wdata_in[`SLC_NVCOPY_DIR_BIT] ||
                     points_out != `SLC_RST_ZERO32;
    end else if (nv_busy_out) begin
      nv_idx_ff <= nv_next[AW-1:0];
      if (nv_next >= nv_len_ff) begin
        nv_busy_out <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // sweep engine
  // ----------------------------------------
  slc_sweep_engine #(
    .HOLD_UNIT_CYC(HOLD_UNIT_CYC)
  ) u_engine (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .trig_in(trig_ff),
    .dir_down_in(list_cfg_in[`SLC_CFG_DIR_BIT]),
    .start_in(start_ff),
    .stop_in(stop_ff),
    .step_in(step_ff),
    .hold_in(hold_ff),
    .repeat_in(repeat_ff),
    .freq_out(freq_out),
    .running_out(sweep_running_out)
  );
endmodule

// ---- pkg/slc_map.vh ----
`ifndef SLC_MAP_VH
`define SLC_MAP_VH
`define SLC_OFF_TRIG 8'h06
`define SLC_OFF_START 8'h07
`define SLC_OFF_STOP 8'h08
`define SLC_OFF_STEP 8'h09
`define SLC_OFF_HOLD 8'h0A
`define SLC_OFF_REPEAT 8'h0B
`define SLC_OFF_POINTS 8'h0C
`define SLC_OFF_STORE 8'h0D
`define SLC_OFF_NVCOPY 8'h0E
`define SLC_OFF_SAVE 8'h0F
`define SLC_OFF_LOWPWR 8'h10
`define SLC_CFG_DIR_BIT 1
`define SLC_NVCOPY_DIR_BIT 0
`define SLC_LOWPWR_BIT 0
`define SLC_PTR_LIMIT 11'h7FF
`define SLC_STORE_END 40'hFFFFFFFFFF
`define SLC_HOLD_UNIT_NS 500000
`define SLC_CLK_PERIOD_NS 100
`define SLC_HOLD_UNIT_CYC (`SLC_HOLD_UNIT_NS / `SLC_CLK_PERIOD_NS)
`define SLC_RST_ZERO40 40'h0000000000
`define SLC_RST_ZERO32 32'h00000000
`endif

// ---- core/slc_sweep_engine.v ----
`timescale 1ns/1ps
`include "slc_map.vh"
module slc_sweep_engine #(
  parameter HOLD_UNIT_CYC = `SLC_HOLD_UNIT_CYC
) (
  input wire ref_clk_in,
  input wire nrst_in,
  input wire trig_in,
  input wire dir_down_in,
  input wire [39:0] start_in,
  input wire [39:0] stop_in,
  input wire [39:0] step_in,
  input wire [31:0] hold_in,
  input wire [31:0] repeat_in,
  output reg [39:0] freq_out,
  output reg running_out
);
  reg [31:0] unit_ff;
  reg [31:0] hold_ff;
  reg [31:0] cycles_ff;
  wire unit_done = (unit_ff >= HOLD_UNIT_CYC - 1);
  wire hold_done = unit_done && (hold_ff + 32'h1 >= hold_in);
  // 41-bit sums so a step near the top of range cannot wrap
  wire [40:0] up_next = {1'b0, freq_out} + {1'b0, step_in};
  wire [40:0] down_floor = {1'b0, start_in} + {1'b0, step_in};
  // the far end itself is a point of the sweep, so end only past it
  wire at_end = dir_down_in ? ({1'b0, freq_out} < down_floor) :
                (up_next > {1'b0, stop_in});
  wire [39:0] begin_f = dir_down_in ? stop_in : start_in;
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      freq_out <= 40'h0;
      running_out <= 1'b0;
      unit_ff <= 32'h0;
      hold_ff <= 32'h0;
      cycles_ff <= 32'h0;
    end else if (trig_in) begin
      // same trigger starts an idle sweep and stops a running one
      running_out <= ~running_out;
      freq_out <= begin_f;
      unit_ff <= 32'h0;
      hold_ff <= 32'h0;
      cycles_ff <= 32'h0;
    end else if (running_out) begin
      unit_ff <= unit_done ? 32'h0 : unit_ff + 32'h1;
      if (unit_done) begin
        hold_ff <= hold_done ? 32'h0 : hold_ff + 32'h1;
      end
      if (hold_done) begin
        if (at_end) begin
          freq_out <= begin_f;
          cycles_ff <= cycles_ff + 32'h1;
          // zero count repeats forever
          if (repeat_in != 32'h0 && cycles_ff + 32'h1 >= repeat_in) begin
            running_out <= 1'b0;
          end
        end else begin
          freq_out <= dir_down_in ? freq_out - step_in : freq_out + step_in;
        end
      end
    end
  end
endmodule

// ---- tb/slc_regs_assertions.sv ----
`timescale 1ns/1ps
module slc_chk (
  input wire ref_clk_in,
  input wire nrst_in,
  input wire wr_in,
  input wire [7:0] addr_in,
  input wire [39:0] wdata_in,
  input wire [39:0] rf_freq_in,
  input wire sweep_running_out,
  input wire standby_out,
  input wire [31:0] points_out,
  input wire [10:0] wr_ptr_out,
  input wire store_enable_out,
  input wire [39:0] saved_rf_freq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  wire st = wr_in && addr_in == 8'h0D;
  wire mid = wdata_in != 40'h0 && !(&wdata_in);
  // ----------------
  // checks
  // ----------------
  trig_toggle_a: assert property (wr_in && addr_in == 8'h06 && wdata_in == 40'h0
    |-> ##2 sweep_running_out != $past(sweep_running_out, 2)) else $error("bad trigger");
  ptr_rewind_a: assert property (st && wdata_in == 40'h0
    |=> wr_ptr_out == 11'h0 && store_enable_out) else $error("bad rewind");
  ptr_step_a: assert property (st && mid && store_enable_out && wr_ptr_out != 11'h7FF
    |=> wr_ptr_out == $past(wr_ptr_out) + 11'h1) else $error("bad step");
  ptr_limit_a: assert property (st && mid && wr_ptr_out == 11'h7FF
    |=> $stable(wr_ptr_out)) else $error("bad limit");
  store_end_a: assert property (st && &wdata_in
    |=> !store_enable_out && points_out == {21'h0, $past(wr_ptr_out)}) else $error("bad end");
  point_cnt_a: assert property (wr_in && addr_in == 8'h0C
    |=> points_out == $past(wdata_in[31:0])) else $error("bad count");
  standby_wr_a: assert property (wr_in && addr_in == 8'h10
    |=> standby_out == $past(wdata_in[0])) else $error("bad standby");
  save_cfg_a: assert property (wr_in && addr_in == 8'h0F
    |=> saved_rf_freq_out == $past(rf_freq_in)) else $error("bad save");
  cover property (st && &wdata_in);
  cover property (sweep_running_out ##1 !sweep_running_out);
  cover property (wr_ptr_out == 11'h7FF);
endmodule

// ---- tb/slc_host.sv ----
`timescale 1ns/1ps
module slc_host (
  input wire ref_clk_in,
  output reg wr_out,
  output reg [7:0] addr_out,
  output reg [39:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 40'h0;
  end
  // one whole field per strobe, spaced two cycles
  task put(input [7:0] a, input [39:0] d);
    begin
      @(negedge ref_clk_in);
      wr_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(negedge ref_clk_in);
      wr_out = 1'b0;
      wdata_out = ~d;
    end
  endtask
endmodule

// ---- tb/sweep_list_control_regs_bench.sv ----
`timescale 1ns/1ps
module sweep_list_control_regs_bench;
  reg ref_clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [7:0] list_cfg_in = 8'h00;
  reg [39:0] rf_freq_in = 40'h0;
  wire wr_in, run, sb, en, busy, smode;
  wire [7:0] addr_in, scfg;
  wire [39:0] wdata_in, freq, sfreq;
  wire [31:0] pts;
  wire [10:0] ptr;
  integer err_total = 0;
  integer n_tests = 0;
  integer i;
  always #50 ref_clk_in = ~ref_clk_in;
  slc_host host_u(.ref_clk_in(ref_clk_in), .wr_out(wr_in), .addr_out(addr_in),
    .wdata_out(wdata_in));
  slc_regs #(.HOLD_UNIT_CYC(4)) dut_u(.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_in), .addr_in(addr_in), .wdata_in(wdata_in), .list_cfg_in(list_cfg_in),
    .rf_freq_in(rf_freq_in), .rf_mode_in(1'b1), .freq_out(freq), .sweep_running_out(run),
    .standby_out(sb), .points_out(pts), .wr_ptr_out(ptr), .store_enable_out(en),
    .nv_busy_out(busy), .saved_list_cfg_out(scfg), .saved_rf_freq_out(sfreq),
    .saved_rf_mode_out(smode));
  task chk(input [39:0] seen, input [39:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // bounded wait on run (b=0), busy (b=1) or freq at 0x64 (b<0); returns cycles
  task wt(input integer b, input v, input integer lim, output integer k);
    begin
      k = 0;
      while ((b > 0 ? busy : (b < 0 ? freq == 40'h64 : run)) !== v && k < lim) begin
        @(negedge ref_clk_in);
        k = k + 1;
      end
      if (k == lim) begin
        chk(k, 0);
        report_and_stop;
      end
    end
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (8) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    chk(freq, 40'h0);
    chk({ptr, sb, run, en}, 14'h0);
    host_u.put(8'h10, 40'h1);
    chk(sb, 1);
    host_u.put(8'h10, 40'h0);
    chk(sb, 0);
    host_u.put(8'h07, 40'h64);
    host_u.put(8'h08, 40'hC8);
    host_u.put(8'h09, 40'h64);
    host_u.put(8'h0A, 40'h2);
    host_u.put(8'h0B, 40'h1);
    host_u.put(8'h06, 40'h1);
    repeat (3) @(negedge ref_clk_in);
    chk(run, 0);
    host_u.put(8'h06, 40'h0);
    wt(0, 1, 5, i);
    chk(freq, 40'h64);
    wt(-1, 0, 20, i);
    chk(i > 6 && i < 10, 1);
    chk(freq, 40'hC8);
    wt(0, 0, 100, i);
    list_cfg_in = 8'h02;
    host_u.put(8'h0B, 40'h0);
    host_u.put(8'h06, 40'h0);
    wt(0, 1, 5, i);
    chk(freq, 40'hC8);
    repeat (100) @(negedge ref_clk_in);
    chk(run, 1);
    host_u.put(8'h06, 40'h0);
    wt(0, 0, 5, i);
    host_u.put(8'h0D, 40'h0);
    chk({en, ptr}, 12'h800);
    for (i = 1; i < 4; i = i + 1)
      host_u.put(8'h0D, i);
    chk(ptr, 3);
    host_u.put(8'h0D, 40'hFFFFFFFFFF);
    chk({en, pts}, 3);
    host_u.put(8'h0D, 40'h5);
    chk(ptr, 3);
    host_u.put(8'h0C, 40'h2);
    chk(pts, 2);
    host_u.put(8'h0E, 40'h1);
    chk(busy, 1);
    wt(1, 0, 3000, i);
    host_u.put(8'h0D, 40'h0);
    for (i = 1; i < 2049; i = i + 1)
      host_u.put(8'h0D, i);
    chk(ptr, 11'h7FF);
    chk(dut_u.list_ram[11'h7FE], 40'h7FF);
    host_u.put(8'h0D, 40'hFFFFFFFFFF);
    chk(pts, 11'h7FF);
    host_u.put(8'h0E, 40'h0);
    chk(busy, 1);
    wt(1, 0, 3000, i);
    chk(dut_u.nv_ram[11'h005], 40'h6);
    rf_freq_in = 40'h123;
    host_u.put(8'h0F, 40'h0);
    chk({scfg, sfreq[31:0]}, 40'h0200000123);
    host_u.put(8'h0D, 40'h0);
    host_u.put(8'h0D, 40'hAA);
    chk(dut_u.list_ram[0], 40'hAA);
    host_u.put(8'h0E, 40'h1);
    wt(1, 0, 3000, i);
    chk(dut_u.list_ram[0], 40'h1);
    // start changed after the save; reset must bring the saved one back
    host_u.put(8'h07, 40'h10);
    @(negedge ref_clk_in);
    nrst_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    chk({run, en, busy}, 3'h0);
    list_cfg_in = 8'h00;
    host_u.put(8'h06, 40'h0);
    wt(0, 1, 5, i);
    chk(freq, 40'h64);
    chk(scfg, 8'h02);
    report_and_stop;
  end
endmodule
bind slc_regs slc_chk chk_u(.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .wr_in(wr_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .rf_freq_in(rf_freq_in),
  .sweep_running_out(sweep_running_out), .standby_out(standby_out), .points_out(points_out),
  .wr_ptr_out(wr_ptr_out), .store_enable_out(store_enable_out),
  .saved_rf_freq_out(saved_rf_freq_out));
